//--- core/kbc_map.svh
/*
 Constants of the keyboard command interpreter: command codes and ranges,
 answer codes, reset values and the host register map.
 Assumes inclusion by bare name from the package and both ends.
*/
`ifndef KBC_MAP_SVH
`define KBC_MAP_SVH

`define KBC_INVALID_HI  8'haa
`define KBC_CMD_ID      8'hab
`define KBC_CMD_EXT_ON  8'hac
`define KBC_CMD_EXT_OFF 8'had
`define KBC_CMD_LMP_ON  8'hae
`define KBC_CMD_LMP_OFF 8'haf
`define KBC_CMD_VOL     8'hb0
`define KBC_CMD_AR_ON   8'hb1
`define KBC_CMD_AR_OFF  8'hb2
`define KBC_CMD_LOCK    8'hb3
`define KBC_CMD_UNLOCK  8'hb4
`define KBC_RSV1_LO     8'hb5
`define KBC_RSV1_HI     8'hec
`define KBC_CMD_LEDS    8'hed
`define KBC_CMD_ECHO    8'hee
`define KBC_RSV2_LO     8'hef
`define KBC_RSV2_HI     8'hf2

`define KBC_ANS_ACK     8'hfa
`define KBC_ANS_RESEND  8'hfe
`define KBC_MODE_STD    8'h01
`define KBC_MODE_EXT    8'h02
`define KBC_VERSION_DEF 8'h01

`define KBC_VOL_OFF     8'h00
`define KBC_VOL_SOFT    8'h02
`define KBC_VOL_MED     8'h04
`define KBC_VOL_LOUD    8'h06
`define KBC_VOL_RST     2'h2
`define KBC_LED_CAPS    2
`define KBC_LED_NUM     1
`define KBC_LED_SCRL    0
`define KBC_VAL_CMD_BIT 7

`define KBC_REG_CMD     12'h000
`define KBC_REG_STAT    12'h004
`define KBC_REG_RX      12'h008
`define KBC_REG_CFG     12'h00c
`define KBC_ST_BUSY     0
`define KBC_ST_RXFULL   1
`define KBC_ST_REFUSED  2
`define KBC_ST_AWAIT    3
`define KBC_CFG_PASS    0

`endif

//--- core/kbc_pkg.sv
/*
 Types shared by both ends of the keyboard command link.
 Assumes the constant header kbc_map.svh is on the include path.
*/
`include "kbc_map.svh"
package kbc_pkg;
	typedef enum logic [3:0] {
		CLS_INVALID, CLS_ID, CLS_EXT_ON, CLS_EXT_OFF, CLS_LMP_ON, CLS_LMP_OFF,
		CLS_VOL, CLS_AR_ON, CLS_AR_OFF, CLS_LOCK, CLS_UNLOCK, CLS_RSVD,
		CLS_LEDS, CLS_ECHO, CLS_OTHER
	} kbc_cls_t;

	typedef enum logic [1:0] {WT_NONE, WT_VOL, WT_LEDS} kbc_wait_t;
endpackage : kbc_pkg

//--- core/kbc_link_if.sv
/*
 Byte link between host controller and keyboard: command bytes one way,
 answer and key bytes the other, each with a valid/ready handshake.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface kbc_link_if;
	logic       cmd_valid;
	logic [7:0] cmd_data;
	logic       cmd_ready;
	logic       rsp_valid;
	logic [7:0] rsp_data;
	logic       rsp_ready;

	modport dev_mp (
		input  cmd_valid,
		input  cmd_data,
		output cmd_ready,
		output rsp_valid,
		output rsp_data,
		input  rsp_ready
	);

	modport host_mp (
		output cmd_valid,
		output cmd_data,
		input  cmd_ready,
		input  rsp_valid,
		input  rsp_data,
		output rsp_ready
	);
endinterface : kbc_link_if

//--- core/kbc_cmd_decode.sv
/*
 Classifies one command byte into its command class.
 Purely combinational; the keyboard end registers everything around it.
*/
`timescale 1ns/1ns
`include "kbc_map.svh"
module kbc_cmd_decode
	import kbc_pkg::*;
(
	input  wire logic [7:0] code_i,
	output kbc_cls_t        cls_o
);
	always_comb
	begin
		cls_o = CLS_OTHER;
		if (code_i <= `KBC_INVALID_HI)
			cls_o = CLS_INVALID;
		else if (code_i >= `KBC_RSV1_LO && code_i <= `KBC_RSV1_HI)
			cls_o = CLS_RSVD;
		else if (code_i >= `KBC_RSV2_LO && code_i <= `KBC_RSV2_HI)
			cls_o = CLS_RSVD;
		else
		begin
			case (code_i)
				`KBC_CMD_ID:      cls_o = CLS_ID;
				`KBC_CMD_EXT_ON:  cls_o = CLS_EXT_ON;
				`KBC_CMD_EXT_OFF: cls_o = CLS_EXT_OFF;
				`KBC_CMD_LMP_ON:  cls_o = CLS_LMP_ON;
				`KBC_CMD_LMP_OFF: cls_o = CLS_LMP_OFF;
				`KBC_CMD_VOL:     cls_o = CLS_VOL;
				`KBC_CMD_AR_ON:   cls_o = CLS_AR_ON;
				`KBC_CMD_AR_OFF:  cls_o = CLS_AR_OFF;
				`KBC_CMD_LOCK:    cls_o = CLS_LOCK;
				`KBC_CMD_UNLOCK:  cls_o = CLS_UNLOCK;
				`KBC_CMD_LEDS:    cls_o = CLS_LEDS;
				`KBC_CMD_ECHO:    cls_o = CLS_ECHO;
				default:          cls_o = CLS_OTHER;
			endcase
		end
	end
endmodule : kbc_cmd_decode

//--- core/kbc_dev.sv
/*
 Keyboard end of the command link: interprets host commands, keeps mode,
 lamps, keyclick volume, autorepeat and chord lock, queues answers and
 forwards key bytes from the scanner.
 Assumes the scanner and link partner share CORE_CLK_I; the chord press
 comes from a key pin and is synchronised here.
*/
`timescale 1ns/1ns
`include "kbc_map.svh"
module kbc_dev
	import kbc_pkg::*;
#(
	// Arbitrary neutral version value
	parameter logic [7:0] VERSION = `KBC_VERSION_DEF
)
(
	input  wire logic       CORE_CLK_I,
	input  wire logic       SYS_RST_I,
	kbc_link_if.dev_mp      LINK,
	input  wire logic       KEY_VALID_I,
	input  wire logic [7:0] KEY_CODE_I,
	output logic            KEY_READY_O,
	input  wire logic       CHORD_PRESS_I,
	output logic            EXT_MODE_O,
	output logic            EXT_MODE_LAMP_O,
	output logic            CAPITALS_LOCK_LAMP_O,
	output logic            NUMERIC_LOCK_LAMP_O,
	output logic            SCROLL_LOCK_LAMP_O,
	output logic [1:0]      CLICK_VOLUME_O,
	output logic            AUTOREPEAT_EN_O,
	output logic            CHORD_EN_O,
	output logic            SCANNING_O
);
	kbc_cls_t   cls;
	kbc_wait_t  wait_q;
	logic [7:0] ans_q [0:1];
	logic [1:0] ans_n_q;
	logic       acc;
	logic       is_val;
	logic       is_cmd;
	logic       pop;
	logic       key_load;
	logic       key_vld_q;
	logic [7:0] key_code_q;
	logic       ext_q;
	logic       lamp4_q;
	logic [2:0] leds_q;
	logic [1:0] vol_q;
	logic       ar_q;
	logic       chord_en_q;
	logic       chord_s1_q;
	logic       chord_s2_q;
	logic       chord_s3_q;
	logic       chord_hit;

	kbc_cmd_decode u_decode (
		.code_i (LINK.cmd_data),
		.cls_o  (cls)
	);

	// One byte at a time: a new command waits until all answers are out
	assign LINK.cmd_ready = (ans_n_q == 2'h0);
	assign acc            = LINK.cmd_valid && LINK.cmd_ready;
	// Value byte only while a two-byte command is pending
	assign is_val = acc && (wait_q != WT_NONE) && !LINK.cmd_data[`KBC_VAL_CMD_BIT];
	assign is_cmd = acc && !is_val;
	assign pop    = LINK.rsp_valid && LINK.rsp_ready;
	// Keys held back while a command is in progress or scanning is stopped
	assign key_load = key_vld_q && (ans_n_q == 2'h0) && !acc && (wait_q == WT_NONE);

	assign LINK.rsp_valid = (ans_n_q != 2'h0);
	assign LINK.rsp_data  = ans_q[0];
	assign KEY_READY_O    = !key_vld_q;
	assign SCANNING_O     = (wait_q == WT_NONE);

	assign EXT_MODE_O           = ext_q;
	assign EXT_MODE_LAMP_O      = lamp4_q;
	assign CAPITALS_LOCK_LAMP_O = leds_q[`KBC_LED_CAPS];
	assign NUMERIC_LOCK_LAMP_O  = leds_q[`KBC_LED_NUM];
	assign SCROLL_LOCK_LAMP_O   = leds_q[`KBC_LED_SCRL];
	assign CLICK_VOLUME_O       = vol_q;
	assign AUTOREPEAT_EN_O      = ar_q;
	assign CHORD_EN_O           = chord_en_q;

	// Answer queue, at most two bytes deep for the identify reply
	always_ff @(posedge CORE_CLK_I)
	begin
		if (SYS_RST_I)
		begin
			ans_n_q  <= 2'h0;
			ans_q[0] <= 8'h00;
			ans_q[1] <= 8'h00;
		end
		else if (is_val)
		begin
			ans_q[0] <= `KBC_ANS_ACK;
			ans_n_q  <= 2'h1;
		end
		else if (is_cmd)
		begin
			case (cls)
				CLS_INVALID:
				begin
					ans_q[0] <= `KBC_ANS_RESEND;
					ans_n_q  <= 2'h1;
				end
				CLS_ID:
				begin
					ans_q[0] <= VERSION;
					ans_q[1] <= ext_q ? `KBC_MODE_EXT : `KBC_MODE_STD;
					ans_n_q  <= 2'h2;
				end
				CLS_ECHO:
				begin
					ans_q[0] <= `KBC_CMD_ECHO;
					ans_n_q  <= 2'h1;
				end
				default:
				begin
					ans_q[0] <= `KBC_ANS_ACK;
					ans_n_q  <= 2'h1;
				end
			endcase
		end
		else if (key_load)
		begin
			ans_q[0] <= key_code_q;
			ans_n_q  <= 2'h1;
		end
		else if (pop)
		begin
			ans_q[0] <= ans_q[1];
			ans_n_q  <= ans_n_q - 2'h1;
		end
	end

	// Pending two-byte command; an aborting byte replaces it
	always_ff @(posedge CORE_CLK_I)
	begin
		if (SYS_RST_I)
			wait_q <= WT_NONE;
		else if (is_cmd)
		begin
			case (cls)
				CLS_VOL:  wait_q <= WT_VOL;
				CLS_LEDS: wait_q <= WT_LEDS;
				default:  wait_q <= WT_NONE;
			endcase
		end
		else if (is_val)
			wait_q <= WT_NONE;
	end

	// Scan mode and extended-mode lamp; a mode or lamp command beats a chord press
	always_ff @(posedge CORE_CLK_I)
	begin
		if (SYS_RST_I)
		begin
			ext_q   <= 1'b0;
			lamp4_q <= 1'b1;
		end
		else if (is_cmd && cls == CLS_EXT_ON)
		begin
			ext_q   <= 1'b1;
			lamp4_q <= 1'b0;
		end
		else if (is_cmd && cls == CLS_EXT_OFF)
		begin
			ext_q   <= 1'b0;
			lamp4_q <= 1'b1;
		end
		else if (is_cmd && cls == CLS_LMP_ON)
			lamp4_q <= 1'b1;
		else if (is_cmd && cls == CLS_LMP_OFF)
			lamp4_q <= 1'b0;
		else if (chord_hit)
			ext_q <= !ext_q;
	end

	// Lock lamps from the value byte; reserved bits ignored
	always_ff @(posedge CORE_CLK_I)
	begin
		if (SYS_RST_I)
			leds_q <= 3'h0;
		else if (is_val && wait_q == WT_LEDS)
			leds_q <= LINK.cmd_data[2:0];
	end

	// Keyclick volume; undefined values keep the old setting
	always_ff @(posedge CORE_CLK_I)
	begin
		if (SYS_RST_I)
			vol_q <= `KBC_VOL_RST;
		else if (is_val && wait_q == WT_VOL)
		begin
			case (LINK.cmd_data)
				`KBC_VOL_OFF:  vol_q <= 2'h0;
				`KBC_VOL_SOFT: vol_q <= 2'h1;
				`KBC_VOL_MED:  vol_q <= 2'h2;
				`KBC_VOL_LOUD: vol_q <= 2'h3;
				default:       vol_q <= vol_q;
			endcase
		end
	end

	// Autorepeat and chord lock
	always_ff @(posedge CORE_CLK_I)
	begin
		if (SYS_RST_I)
		begin
			ar_q       <= 1'b1;
			chord_en_q <= 1'b1;
		end
		else if (is_cmd)
		begin
			case (cls)
				CLS_AR_ON:  ar_q       <= 1'b1;
				CLS_AR_OFF: ar_q       <= 1'b0;
				CLS_LOCK:   chord_en_q <= 1'b0;
				CLS_UNLOCK: chord_en_q <= 1'b1;
				default:    chord_en_q <= chord_en_q;
			endcase
		end
	end

	// One-byte output buffer from the scanner; identify flushes it
	always_ff @(posedge CORE_CLK_I)
	begin
		if (SYS_RST_I)
		begin
			key_vld_q  <= 1'b0;
			key_code_q <= 8'h00;
		end
		else if (KEY_VALID_I && !key_vld_q)
		begin
			key_vld_q  <= 1'b1;
			key_code_q <= KEY_CODE_I;
		end
		else if (key_load || (is_cmd && cls == CLS_ID))
			key_vld_q <= 1'b0;
	end

	// Chord pin synchroniser and rising-edge detect
	always_ff @(posedge CORE_CLK_I)
	begin
		if (SYS_RST_I)
		begin
			chord_s1_q <= 1'b0;
			chord_s2_q <= 1'b0;
			chord_s3_q <= 1'b0;
		end
		else
		begin
			chord_s1_q <= CHORD_PRESS_I;
			chord_s2_q <= chord_s1_q;
			chord_s3_q <= chord_s2_q;
		end
	end

	assign chord_hit = chord_en_q && chord_s2_q && !chord_s3_q;
endmodule : kbc_dev

//--- core/kbc_host.sv
/*
 Host end of the keyboard command link: software writes command bytes and
 reads answers through APB registers.
 Assumes an APB master on CORE_CLK_I; key bytes arrive untranslated.
*/
`timescale 1ns/1ns
`include "kbc_map.svh"
module kbc_host
	import kbc_pkg::*;
(
	input  wire logic        CORE_CLK_I,
	input  wire logic        SYS_RST_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [11:0] PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic [31:0]      PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	kbc_link_if.host_mp      LINK
);
	logic        tx_pend_q;
	logic [7:0]  tx_q;
	logic        await_q;
	logic        rx_full_q;
	logic [7:0]  rx_q;
	logic        refused_q;
	logic        pass_q;
	logic [31:0] rdata_q;
	logic        setup;
	logic        acc;
	logic        mapped;
	logic        wr_cmd;
	logic        bad_cmd;
	logic        sent;
	logic        got;

	assign mapped = (PADDR_I == `KBC_REG_CMD) || (PADDR_I == `KBC_REG_STAT) ||
			(PADDR_I == `KBC_REG_RX) || (PADDR_I == `KBC_REG_CFG);
	assign setup     = PSEL_I && !PENABLE_I;
	assign acc       = PSEL_I && PENABLE_I;
	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = acc && !mapped;
	assign PRDATA_O  = rdata_q;

	assign wr_cmd  = acc && PWRITE_I && (PADDR_I == `KBC_REG_CMD);
	// Identify refused unless pass-through, else answers would be translated
	assign bad_cmd = wr_cmd && (tx_pend_q || (PWDATA_I[7:0] == `KBC_CMD_ID && !pass_q));

	// Next byte held until the previous one has been answered
	assign LINK.cmd_valid = tx_pend_q && !await_q;
	assign LINK.cmd_data  = tx_q;
	assign LINK.rsp_ready = 1'b1;
	assign sent           = LINK.cmd_valid && LINK.cmd_ready;
	assign got            = LINK.rsp_valid;

	// Read data captured in setup so it stands from a flop during access
	always_ff @(posedge CORE_CLK_I)
	begin
		if (SYS_RST_I)
			rdata_q <= 32'h0;
		else if (setup && !PWRITE_I)
		begin
			case (PADDR_I)
				`KBC_REG_STAT: rdata_q <= {28'h0, await_q, refused_q, rx_full_q, tx_pend_q};
				`KBC_REG_RX:   rdata_q <= {24'h0, rx_q};
				`KBC_REG_CFG:  rdata_q <= {31'h0, pass_q};
				default:       rdata_q <= 32'h0;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK_I)
	begin
		if (SYS_RST_I)
		begin
			tx_pend_q <= 1'b0;
			tx_q      <= 8'h00;
		end
		else if (wr_cmd && !bad_cmd)
		begin
			tx_pend_q <= 1'b1;
			tx_q      <= PWDATA_I[7:0];
		end
		else if (sent)
			tx_pend_q <= 1'b0;
	end

	// Any received byte ends the wait, unsolicited key bytes included
	always_ff @(posedge CORE_CLK_I)
	begin
		if (SYS_RST_I)
			await_q <= 1'b0;
		else if (sent)
			await_q <= 1'b1;
		else if (got)
			await_q <= 1'b0;
	end

	// Sticky flags: a new event wins over a clear in the same cycle
	always_ff @(posedge CORE_CLK_I)
	begin
		if (SYS_RST_I)
		begin
			rx_full_q <= 1'b0;
			rx_q      <= 8'h00;
			refused_q <= 1'b0;
		end
		else
		begin
			if (got)
			begin
				rx_full_q <= 1'b1;
				rx_q      <= LINK.rsp_data;
			end
			else if (acc && !PWRITE_I && PADDR_I == `KBC_REG_RX)
				rx_full_q <= 1'b0;
			if (bad_cmd)
				refused_q <= 1'b1;
			else if (acc && PWRITE_I && PADDR_I == `KBC_REG_STAT && PWDATA_I[`KBC_ST_REFUSED])
				refused_q <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK_I)
	begin
		if (SYS_RST_I)
			pass_q <= 1'b0;
		else if (acc && PWRITE_I && PADDR_I == `KBC_REG_CFG)
			pass_q <= PWDATA_I[`KBC_CFG_PASS];
	end
endmodule : kbc_host

//--- dv/kbc_link_monitor.sv
/*
 Checker of the command link between the two ends.
 Assumes one clock and every answer registered one cycle after its command.
*/
`timescale 1ns/1ns
`include "kbc_map.svh"
module kbc_link_monitor (
	input wire logic       CORE_CLK_I,
	input wire logic       SYS_RST_I,
	input wire logic       cmd_valid_i,
	input wire logic [7:0] cmd_data_i,
	input wire logic       cmd_ready_i,
	input wire logic       rsp_valid_i,
	input wire logic [7:0] rsp_data_i,
	input wire logic       rsp_ready_i
);
	logic tk;
	logic val;
	logic wait_q;
	assign tk  = cmd_valid_i & cmd_ready_i;
	// Low value bytes are never commands
	assign val = tk & wait_q & ~cmd_data_i[`KBC_VAL_CMD_BIT];
	always_ff @(posedge CORE_CLK_I)
	begin
		if (SYS_RST_I)
			wait_q <= 1'b0;
		else if (tk)
			wait_q <= (cmd_data_i == `KBC_CMD_VOL) | (cmd_data_i == `KBC_CMD_LEDS);
	end
	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (SYS_RST_I);
	AST_INVALID: assert property (tk && !val && cmd_data_i <= `KBC_INVALID_HI
		|=> rsp_valid_i && rsp_data_i == `KBC_ANS_RESEND) else $error("no resend");
	AST_ID_FIRST: assert property (tk && cmd_data_i == `KBC_CMD_ID
		|=> rsp_valid_i && rsp_data_i != `KBC_ANS_ACK) else $error("ack on identify");
	// Mode byte only once the version byte has been taken
	AST_ID_MODE: assert property (tk && cmd_data_i == `KBC_CMD_ID
		|=> rsp_ready_i ##1 (rsp_valid_i &&
		rsp_data_i inside {`KBC_MODE_STD, `KBC_MODE_EXT})) else $error("bad mode byte");
	AST_ID_END: assert property (tk && cmd_data_i == `KBC_CMD_ID
		|=> ##2 !rsp_valid_i) else $error("extra byte after identify");
	AST_LAMP_MODE: assert property (
		tk && (cmd_data_i inside {[`KBC_CMD_EXT_ON:`KBC_CMD_LMP_OFF]} ||
		cmd_data_i inside {[`KBC_CMD_AR_ON:`KBC_CMD_UNLOCK]})
		|=> rsp_valid_i && rsp_data_i == `KBC_ANS_ACK) else $error("no ack");
	AST_PAIR: assert property (tk && cmd_data_i inside {`KBC_CMD_VOL, `KBC_CMD_LEDS}
		|=> rsp_valid_i && rsp_data_i == `KBC_ANS_ACK) else $error("no first ack");
	AST_VALUE: assert property (val
		|=> rsp_valid_i && rsp_data_i == `KBC_ANS_ACK) else $error("no value ack");
	AST_RSVD: assert property (
		tk && (cmd_data_i inside {[`KBC_RSV1_LO:`KBC_RSV1_HI]} ||
		cmd_data_i inside {[`KBC_RSV2_LO:`KBC_RSV2_HI]})
		|=> rsp_valid_i && rsp_data_i == `KBC_ANS_ACK) else $error("no reserved ack");
	AST_ECHO: assert property (tk && cmd_data_i == `KBC_CMD_ECHO
		|=> rsp_valid_i && rsp_data_i == `KBC_CMD_ECHO) else $error("no echo");
	// Host holds its next byte until an answer has come back
	AST_HOST_WAIT: assert property (tk
		|=> !cmd_valid_i) else $error("byte offered before answer");
endmodule : kbc_link_monitor

//--- dv/keyboard_host_command_interpreter_tb_top.sv
/*
 Self-checking bench: APB master on the host end, keyboard end beside it.
 Assumes one clock for both ends; the host end takes every answer.
*/
`timescale 1ns/1ns
module keyboard_host_command_interpreter_tb_top
	import kbc_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [11:0] padr = 12'h000;
	logic [31:0] pwd = 32'h0;
	logic [31:0] prd;
	logic        prdy;
	logic        perr;
	logic        kv = 1'b0;
	logic [7:0]  kc = 8'h00;
	logic        chord = 1'b0;
	logic        ext, lamp, caps, num, scrl, ar, chen, scan, kr;
	logic [1:0]  vol;
	logic [7:0]  rx_q[$];
	logic [31:0] rd;
	logic        er;
	int          num_errors = 0;
	int          compares = 0;
	int          cyc = 0;
	// Command, answer, then {mode, lamp, autorepeat, chord enable}
	logic [19:0] tab[16] = '{20'h00fe7, 20'haafe7, 20'hacfab, 20'hadfa7, 20'haffa3,
		20'haefa7, 20'hb2fa5, 20'hb1fa7, 20'hb3fa6, 20'hb4fa7, 20'hb5fa7, 20'hecfa7,
		20'heeee7, 20'heffa7, 20'hf2fa7, 20'hf3fa7};

	kbc_link_if u_kbc_link_if ();
	kbc_host u_kbc_host (.CORE_CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy),
		.PSLVERR_O(perr), .LINK(u_kbc_link_if.host_mp));
	kbc_dev u_kbc_dev (.CORE_CLK_I(clk), .SYS_RST_I(rst), .LINK(u_kbc_link_if.dev_mp),
		.KEY_VALID_I(kv), .KEY_CODE_I(kc), .KEY_READY_O(kr), .CHORD_PRESS_I(chord),
		.EXT_MODE_O(ext), .EXT_MODE_LAMP_O(lamp), .CAPITALS_LOCK_LAMP_O(caps),
		.NUMERIC_LOCK_LAMP_O(num), .SCROLL_LOCK_LAMP_O(scrl), .CLICK_VOLUME_O(vol),
		.AUTOREPEAT_EN_O(ar), .CHORD_EN_O(chen), .SCANNING_O(scan));
	kbc_link_monitor u_kbc_link_monitor (.CORE_CLK_I(clk), .SYS_RST_I(rst),
		.cmd_valid_i(u_kbc_link_if.cmd_valid), .cmd_data_i(u_kbc_link_if.cmd_data),
		.cmd_ready_i(u_kbc_link_if.cmd_ready), .rsp_valid_i(u_kbc_link_if.rsp_valid),
		.rsp_data_i(u_kbc_link_if.rsp_data), .rsp_ready_i(u_kbc_link_if.rsp_ready));

	always #2 clk = ~clk;

	// Every byte the host takes, plus the hang guard
	always @(posedge clk)
	begin
		if (u_kbc_link_if.rsp_valid && u_kbc_link_if.rsp_ready)
			rx_q.push_back(u_kbc_link_if.rsp_data);
		cyc++;
		if (cyc == 6000)
		begin
			num_errors++;
			finish_test();
		end
	end

	task chk8(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e)
		begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk8

	task chk32(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk32

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		// Request held until pready is seen high at a rising edge
		do
		begin
			@(posedge clk);
		end
		while (prdy !== 1'b1);
		rd = prd;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	task send(input logic [7:0] c, input int n);
		int k;
		rx_q.delete();
		apb(1'b1, 12'h000, {24'h0, c});
		k = 0;
		while (rx_q.size() < n && k < 40)
		begin
			@(posedge clk);
			k++;
		end
	endtask : send

	task pulse;
		@(posedge clk);
		chord <= 1'b1;
		repeat (4) @(posedge clk);
		chord <= 1'b0;
		repeat (6) @(posedge clk);
	endtask : pulse

	task finish_test;
		$display("compares=%0d num_errors=%0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test

	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 16; i++)
		begin
			send(tab[i][19:12], 1);
			chk8(rx_q[0], tab[i][11:4]);
			chk32({28'h0, ext, lamp, ar, chen}, {28'h0, tab[i][3:0]});
		end
		$display("table done");
		for (int i = 0; i < 4; i++)
		begin
			send(8'hb0, 1);
			chk8({7'h0, scan}, 8'h00);
			send(8'(i * 2), 1);
			chk8(rx_q[0], 8'hfa);
			chk8({5'h0, scan, vol}, 8'(4 + i));
		end
		$display("volume done");
		send(8'hb0, 1);
		send(8'hac, 1);
		chk8({rx_q[0][7:4], ext, scan, vol}, 8'hff);
		send(8'hed, 1);
		send(8'h05, 1);
		chk8({5'h0, caps, num, scrl}, 8'h05);
		send(8'hed, 1);
		send(8'h02, 1);
		chk8({4'h0, scan, caps, num, scrl}, 8'h0a);
		$display("abort and lamps done");
		apb(1'b1, 12'h00c, 32'h1);
		send(8'hab, 2);
		chk8(rx_q[0], 8'h01);
		chk8(rx_q[1], 8'h02);
		apb(1'b0, 12'h008, 32'h0);
		chk32(rd, 32'h2);
		// Identify without pass-through is refused by the host
		apb(1'b1, 12'h00c, 32'h0);
		apb(1'b1, 12'h000, 32'hab);
		apb(1'b0, 12'h004, 32'h0);
		chk32(rd, 32'h4);
		apb(1'b1, 12'h004, 32'h4);
		apb(1'b0, 12'h004, 32'h0);
		chk32(rd, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		chk8({7'h0, er}, 8'h01);
		$display("identify and registers done");
		pulse();
		chk8({7'h0, ext}, 8'h00);
		send(8'hb3, 1);
		pulse();
		chk8({6'h0, ext, chen}, 8'h00);
		send(8'hb4, 1);
		pulse();
		chk8({6'h0, ext, chen}, 8'h03);
		$display("chord done");
		rx_q.delete();
		@(posedge clk);
		kv <= 1'b1;
		kc <= 8'h1c;
		@(posedge clk);
		kv <= 1'b0;
		repeat (8) @(posedge clk);
		chk8(rx_q[0], 8'h1c);
		$display("key done");
		// Key held while a lamp byte is awaited, then flushed by identify
		apb(1'b1, 12'h00c, 32'h1);
		send(8'hed, 1);
		@(posedge clk);
		kv <= 1'b1;
		kc <= 8'h2a;
		@(posedge clk);
		kv <= 1'b0;
		repeat (4) @(posedge clk);
		chk8({7'h0, kr}, 8'h00);
		send(8'hab, 2);
		repeat (8) @(posedge clk);
		chk8(8'(rx_q.size()), 8'h02);
		chk8(rx_q[1], 8'h02);
		chk8({7'h0, kr}, 8'h01);
		$display("flush done");
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk8({ext, lamp, ar, chen, caps, num, scrl, scan}, 8'h71);
		chk8({5'h0, kr, vol}, 8'h06);
		$display("reset done");
		finish_test();
	end
endmodule : keyboard_host_command_interpreter_tb_top
